// [serial1_pkg.sv]
// shared constants and types for the serial port 1 control block
// assumes an 8-bit register port and a shift engine on the same clock
package serial1_pkg;

    // register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'hF8;
    localparam logic [7:0] AUX_ADDR = 8'hF9;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'hFA;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'hFB;

    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic AUX_FE_SEL_RESET = 1'b0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // control register field positions
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_MPC = 5;
    localparam int CTRL_REN = 4;
    localparam int CTRL_TB8 = 3;
    localparam int CTRL_RB8 = 2;
    localparam int CTRL_TI = 1;
    localparam int CTRL_RI = 0;

    // auxiliary register field positions
    localparam int AUX_FE_SEL = 0;

    // interrupt status and mask field positions
    localparam int ST_RI = 0;
    localparam int ST_TI = 1;
    localparam int ST_FE = 2;
    localparam int ST_WIDTH = 3;

    typedef enum logic [1:0] {
        MODE0 = 2'b00,
        MODE1 = 2'b01,
        MODE2 = 2'b10,
        MODE3 = 2'b11
    } ser_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // end of a received frame, reported by the shift engine
    typedef struct packed {
        logic valid;
        logic ninth;
        logic addr_match;
        logic frame_err;
    } rx_event_t;

    // steering for the shift engine
    typedef struct packed {
        ser_mode_t mode;
        logic rx_enable;
        logic rx_start_ok;
        logic mp_check;
        logic tx_ninth;
    } engine_ctrl_t;

endpackage

// [serial1_control.sv]
// control and status register for serial port 1, with its interrupt
// assumes a shift engine on i_mclk that reports frame ends as one-cycle
// pulses, and a register master that never needs a wait state
`timescale 1ns/1ns

// Overview of operation
// RQ1: an 8-bit control register sits at F8 and resets to all zeros.
// RQ2: bit 7 reads as the high mode bit, or as the frame error flag when selected.
// RQ3: a framing error sets the frame error flag, which only software clears.
// RQ4: the multiprocessor check bit depends on mode and does nothing in mode 0.
// RQ5: in mode 1 with the check on, a frame needs stop bit 1 and an address match.
// RQ6: in modes 2 and 3 with the check on, a frame needs ninth bit 1 and a match.
// RQ7: receive enable low blocks reception; high enables it in modes 1 to 3.
// RQ8: in mode 0 a reception starts only with receive enabled and rx done clear.
// RQ9: in modes 2 and 3 the ninth transmit bit goes out as the ninth data bit.
// RQ10: the ninth receive bit takes the ninth bit, or the stop bit in mode 1.
// RQ11: the transmit done flag is set by hardware when a frame has gone out.
// RQ12: the receive done flag is set at frame end, subject to the address check.
// RQ13: the interrupt is raised while an enabled done flag is set.
// RQ14: software clears the done flags; hardware never clears them.
// RQ15: the select bit routes bit 7 accesses to the mode bit or the error flag.
// RQ16: the two mode bits, high first, decode modes 0 to 3.
module serial1_control
    import serial1_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire reg_req_t i_req,
    output logic [7:0] o_rdata,
    input wire logic i_tx_done,
    input wire rx_event_t i_rx,
    output engine_ctrl_t o_ctrl,
    output logic o_irq
);

    logic mode_hi_r;
    logic mode_lo_r;
    logic mpc_r;
    logic ren_r;
    logic tb8_r;
    logic rb8_r;
    logic ti_r;
    logic ri_r;
    logic fe_r;
    logic fe_sel_r;
    logic [ST_WIDTH-1:0] mask_r;
    logic [7:0] rdata_r;
    logic irq_r;
    engine_ctrl_t ctrl_out_r;

    logic mode_hi_nxt;
    logic mode_lo_nxt;
    logic mpc_nxt;
    logic ren_nxt;
    logic tb8_nxt;
    logic rb8_nxt;
    logic ti_nxt;
    logic ri_nxt;
    logic fe_nxt;
    logic fe_sel_nxt;
    logic [ST_WIDTH-1:0] mask_nxt;
    logic [ST_WIDTH-1:0] status_nxt;
    engine_ctrl_t ctrl_out_nxt;

    logic wr_ctrl;
    logic wr_aux;
    logic wr_stat;
    logic wr_mask;
    ser_mode_t mode;
    logic rx_live;
    logic rx_take;
    logic rx_load_ninth;
    logic fe_set;
    logic [7:0] ctrl_view;
    logic [7:0] read_mux;

    // modes that carry a ninth data bit on the line
    function automatic logic nine_bit_mode(input ser_mode_t m);
        return (m == MODE2) || (m == MODE3);
    endfunction

    // RQ16 mode decode
    function automatic ser_mode_t decode_mode(input logic hi, input logic lo);
        return ser_mode_t'({hi, lo});
    endfunction

    assign wr_ctrl = i_req.wr && (i_req.addr == CTRL_ADDR);
    assign wr_aux = i_req.wr && (i_req.addr == AUX_ADDR);
    assign wr_stat = i_req.wr && (i_req.addr == IRQ_STAT_ADDR);
    assign wr_mask = i_req.wr && (i_req.addr == IRQ_MASK_ADDR);
    assign mode = decode_mode(mode_hi_r, mode_lo_r);

    // RQ7 reception gated
    assign rx_live = i_rx.valid && ren_r;

    // RQ3 framing error
    assign fe_set = rx_live && i_rx.frame_err;

    // address check decides whether a finished frame counts
    always_comb begin
        rx_take = 1'b0;
        rx_load_ninth = 1'b0;
        case (mode)
            // RQ4 check bit ignored
            MODE0: begin
                rx_take = rx_live && !ri_r;
            end
            // RQ5 stop bit check
            MODE1: begin
                rx_take = rx_live && (!mpc_r || (i_rx.ninth && i_rx.addr_match));
                rx_load_ninth = rx_take;
            end
            // RQ6 ninth bit check
            MODE2, MODE3: begin
                rx_take = rx_live && (!mpc_r || (i_rx.ninth && i_rx.addr_match));
                rx_load_ninth = rx_take;
            end
            default: begin
                rx_take = 1'b0;
                rx_load_ninth = 1'b0;
            end
        endcase
    end

    // plain control fields
    always_comb begin
        mode_lo_nxt = mode_lo_r;
        mpc_nxt = mpc_r;
        ren_nxt = ren_r;
        tb8_nxt = tb8_r;
        if (wr_ctrl) begin
            mode_lo_nxt = i_req.wdata[CTRL_MODE_LO];
            mpc_nxt = i_req.wdata[CTRL_MPC];
            ren_nxt = i_req.wdata[CTRL_REN];
            tb8_nxt = i_req.wdata[CTRL_TB8];
        end
    end

    // RQ15 bit 7 routing
    always_comb begin
        mode_hi_nxt = mode_hi_r;
        if (wr_ctrl && !fe_sel_r) begin
            mode_hi_nxt = i_req.wdata[CTRL_MODE_HI];
        end
    end

    // RQ10 ninth receive bit
    always_comb begin
        rb8_nxt = rb8_r;
        if (wr_ctrl) begin
            rb8_nxt = i_req.wdata[CTRL_RB8];
        end
        if (rx_load_ninth) begin
            rb8_nxt = i_rx.ninth;
        end
    end

    // flags: a hardware set in the same cycle as a software clear wins
    always_comb begin
        ti_nxt = ti_r;
        ri_nxt = ri_r;
        fe_nxt = fe_r;
        if (wr_ctrl) begin
            ti_nxt = i_req.wdata[CTRL_TI];
            ri_nxt = i_req.wdata[CTRL_RI];
            if (fe_sel_r) begin
                fe_nxt = i_req.wdata[CTRL_MODE_HI];
            end
        end
        if (wr_stat) begin
            if (i_req.wdata[ST_TI]) begin
                ti_nxt = 1'b0;
            end
            if (i_req.wdata[ST_RI]) begin
                ri_nxt = 1'b0;
            end
            if (i_req.wdata[ST_FE]) begin
                fe_nxt = 1'b0;
            end
        end
        // RQ11 transmit done
        if (i_tx_done) begin
            ti_nxt = 1'b1;
        end
        // RQ12 receive done
        if (rx_take) begin
            ri_nxt = 1'b1;
        end
        // RQ3 error set
        if (fe_set) begin
            fe_nxt = 1'b1;
        end
    end

    assign fe_sel_nxt = wr_aux ? i_req.wdata[AUX_FE_SEL] : fe_sel_r;
    assign mask_nxt = wr_mask ? i_req.wdata[ST_WIDTH-1:0] : mask_r;
    assign status_nxt = {fe_nxt, ti_nxt, ri_nxt};

    // engine steering, registered from next values so it tracks the register
    always_comb begin
        ctrl_out_nxt.mode = decode_mode(mode_hi_nxt, mode_lo_nxt);
        ctrl_out_nxt.rx_enable = ren_nxt;
        ctrl_out_nxt.mp_check = mpc_nxt && (ctrl_out_nxt.mode != MODE0);
        // RQ8 mode 0 start gate
        ctrl_out_nxt.rx_start_ok = ren_nxt && ((ctrl_out_nxt.mode != MODE0) || !ri_nxt);
        // RQ9 ninth transmit bit
        ctrl_out_nxt.tx_ninth = tb8_nxt && nine_bit_mode(ctrl_out_nxt.mode);
    end

    // RQ2 bit 7 view
    assign ctrl_view = {fe_sel_r ? fe_r : mode_hi_r, mode_lo_r, mpc_r, ren_r,
                        tb8_r, rb8_r, ti_r, ri_r};

    always_comb begin
        case (i_req.addr)
            CTRL_ADDR: read_mux = ctrl_view;
            AUX_ADDR: read_mux = {7'h00, fe_sel_r};
            IRQ_STAT_ADDR: read_mux = {5'h00, fe_r, ti_r, ri_r};
            IRQ_MASK_ADDR: read_mux = {5'h00, mask_r};
            default: read_mux = RDATA_IDLE;
        endcase
    end

    // RQ1 control register storage
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode_hi_r <= CTRL_RESET[CTRL_MODE_HI];
            mode_lo_r <= CTRL_RESET[CTRL_MODE_LO];
            mpc_r <= CTRL_RESET[CTRL_MPC];
            ren_r <= CTRL_RESET[CTRL_REN];
            tb8_r <= CTRL_RESET[CTRL_TB8];
            rb8_r <= CTRL_RESET[CTRL_RB8];
        end else if (i_ce) begin
            mode_hi_r <= mode_hi_nxt;
            mode_lo_r <= mode_lo_nxt;
            mpc_r <= mpc_nxt;
            ren_r <= ren_nxt;
            tb8_r <= tb8_nxt;
            rb8_r <= rb8_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ti_r <= CTRL_RESET[CTRL_TI];
            ri_r <= CTRL_RESET[CTRL_RI];
            fe_r <= 1'b0;
        end else if (i_ce) begin
            ti_r <= ti_nxt;
            ri_r <= ri_nxt;
            fe_r <= fe_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            fe_sel_r <= AUX_FE_SEL_RESET;
            mask_r <= IRQ_MASK_RESET;
        end else if (i_ce) begin
            fe_sel_r <= fe_sel_nxt;
            mask_r <= mask_nxt;
        end
    end

    // read data holds only in the cycle after the strobe
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= RDATA_IDLE;
        end else if (i_ce) begin
            rdata_r <= i_req.rd ? read_mux : RDATA_IDLE;
        end
    end

    // RQ13 interrupt request
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_r <= 1'b0;
        end else if (i_ce) begin
            irq_r <= |(status_nxt & mask_nxt);
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_out_r <= '0;
        end else if (i_ce) begin
            ctrl_out_r <= ctrl_out_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_irq = irq_r;
    assign o_ctrl = ctrl_out_r;

    ctrl_read_a: assert property ( // RQ1
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && i_req.rd && (i_req.addr == CTRL_ADDR) |=> o_rdata == $past(ctrl_view)
    ) else $error("control register read data wrong");

    bit7_view_a: assert property ( // RQ2
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && i_req.rd && (i_req.addr == CTRL_ADDR) && fe_sel_r
        |=> o_rdata[CTRL_MODE_HI] == $past(fe_r)
    ) else $error("bit 7 does not show the frame error flag");

    fe_sticky_a: assert property ( // RQ3
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && fe_set |=> fe_r
    ) else $error("frame error flag not set");

    mode0_take_a: assert property ( // RQ4
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && (mode == MODE0) && rx_live && !ri_r |=> ri_r
    ) else $error("mode 0 frame lost");

    mp_reject_a: assert property ( // RQ5
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && (mode != MODE0) && mpc_r && rx_live && !(i_rx.ninth && i_rx.addr_match)
        && !ri_r && !i_req.wr |=> !ri_r
    ) else $error("unaddressed frame accepted");

    rb8_load_a: assert property ( // RQ10
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && (mode != MODE0) && rx_take |=> rb8_r == $past(i_rx.ninth)
    ) else $error("ninth receive bit not loaded");

    rx_disable_a: assert property ( // RQ7
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && !ren_r && !ri_r && !i_req.wr |=> !ri_r
    ) else $error("reception while disabled");

    start_gate_a: assert property ( // RQ8
        @(posedge i_mclk) disable iff (i_rst)
        o_ctrl.rx_start_ok && (o_ctrl.mode == MODE0) |-> ren_r && !ri_r
    ) else $error("mode 0 start allowed with rx done set");

    tx_ninth_a: assert property ( // RQ9
        @(posedge i_mclk) disable iff (i_rst)
        o_ctrl.tx_ninth == (tb8_r && mode[1])
    ) else $error("ninth transmit bit wrong for mode");

    tx_done_a: assert property ( // RQ11
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && i_tx_done |=> ti_r ##1 (ti_r || $past(i_req.wr))
    ) else $error("transmit done flag not set");

    irq_level_a: assert property ( // RQ13
        @(posedge i_mclk) disable iff (i_rst)
        o_irq == |({fe_r, ti_r, ri_r} & mask_r)
    ) else $error("interrupt does not follow enabled flags");

    sel_route_a: assert property ( // RQ15
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && wr_ctrl && fe_sel_r |=> mode_hi_r == $past(mode_hi_r)
    ) else $error("mode bit written while error view selected");

    mode_decode_a: assert property ( // RQ16
        @(posedge i_mclk) disable iff (i_rst)
        o_ctrl.mode == ser_mode_t'({mode_hi_r, mode_lo_r})
    ) else $error("mode decode mismatch");

    rx_done_a: assert property ( // RQ12
        @(posedge i_mclk) disable iff (i_rst)
        i_ce && rx_take |=> ri_r
    ) else $error("receive done flag not set");

endmodule

// [far_engine.sv]
// far side model: shift engine and remote serial device for serial port 1
// assumes the bench calls its tasks; events change just after i_mclk edges
`timescale 1ns/1ns
module far_engine
    import serial1_pkg::*;
(
    input wire logic i_mclk,
    input wire engine_ctrl_t i_ctrl,
    output rx_event_t o_rx,
    output logic o_tx_done,
    output logic o_sent_ninth
);
    initial begin
        o_rx = '0;
        o_tx_done = 1'b0;
        o_sent_ninth = 1'b0;
    end

    task automatic rx_frame(input logic ninth, input logic match, input logic err);
        @(posedge i_mclk);
        o_rx <= '{valid: 1'b1, ninth: ninth, addr_match: match, frame_err: err};
        @(posedge i_mclk);
        // qualifiers are stale after the pulse, so show their inverse
        o_rx <= '{valid: 1'b0, ninth: ~ninth, addr_match: ~match, frame_err: ~err};
        #1;
    endtask

    task automatic tx_frame();
        @(posedge i_mclk);
        o_sent_ninth <= i_ctrl.tx_ninth;
        o_tx_done <= 1'b1;
        @(posedge i_mclk);
        o_tx_done <= 1'b0;
        #1;
    endtask
endmodule

// [testbench.sv]
// self-checking bench for the serial port 1 control register block
// assumes far_engine stands in for the shift engine and remote device
`timescale 1ns/1ns
module testbench;
    import serial1_pkg::*;
    logic i_mclk;
    logic i_rst;
    logic i_ce;
    reg_req_t req;
    logic [7:0] rdata;
    logic tx_done;
    rx_event_t rx;
    engine_ctrl_t ctrl;
    logic irq;
    logic sent_ninth;
    int num_errors = 0;
    int tests_run = 0;
    int m;

    serial1_control DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_req(req),
        .o_rdata(rdata), .i_tx_done(tx_done), .i_rx(rx), .o_ctrl(ctrl), .o_irq(irq));
    far_engine far (.i_mclk(i_mclk), .i_ctrl(ctrl), .o_rx(rx), .o_tx_done(tx_done),
        .o_sent_ninth(sent_ninth));

    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_mclk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_mclk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: 8'h00};
        #1;
        check(rdata, exp);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // under two hundred cycles are expected; far beyond that means a hang
    initial begin
        #100000;
        num_errors++;
        results();
    end

    initial begin
        i_rst = 1'b1;
        i_ce = 1'b1;
        req = '0;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        check({2'h0, ctrl}, 8'h00);
        check({7'h0, irq}, 8'h00);
        rd(CTRL_ADDR, CTRL_RESET);
        rd(AUX_ADDR, 8'h00);
        rd(IRQ_STAT_ADDR, 8'h00);
        rd(IRQ_MASK_ADDR, 8'h00);
        wr(8'hF7, 8'hFF);
        rd(8'hF7, RDATA_IDLE);
        rd(CTRL_ADDR, 8'h00);
        // every mode with check, enable and ninth bit set
        for (m = 0; m < 4; m++) begin
            wr(CTRL_ADDR, {m[1:0], 6'h38});
            check({6'h0, ctrl.mode}, {6'h0, m[1:0]});
            check({7'h0, ctrl.mp_check}, {7'h0, m != 0});
            check({7'h0, ctrl.tx_ninth}, {7'h0, m >= 2});
            check({6'h0, ctrl.rx_enable, ctrl.rx_start_ok}, 8'h03);
            far.tx_frame();
            check({7'h0, sent_ninth}, {7'h0, m >= 2});
            rd(CTRL_ADDR, {m[1:0], 6'h3A});
            wr(CTRL_ADDR, 8'h00);
        end
        // bit 7 routing and the frame error flag
        wr(CTRL_ADDR, 8'h80);
        wr(AUX_ADDR, 8'h01);
        rd(AUX_ADDR, 8'h01);
        rd(CTRL_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h10);
        check({6'h0, ctrl.mode}, {6'h0, MODE2});
        far.rx_frame(1'b1, 1'b1, 1'b1);
        repeat (5) @(posedge i_mclk);
        rd(CTRL_ADDR, 8'h95);
        rd(IRQ_STAT_ADDR, 8'h05);
        wr(CTRL_ADDR, 8'h14);
        rd(CTRL_ADDR, 8'h14);
        rd(IRQ_STAT_ADDR, 8'h00);
        wr(AUX_ADDR, 8'h00);
        rd(CTRL_ADDR, 8'h94);
        // receive enable off, then mode 1 without check
        wr(CTRL_ADDR, 8'h40);
        check({6'h0, ctrl.rx_enable, ctrl.rx_start_ok}, 8'h00);
        far.rx_frame(1'b1, 1'b1, 1'b0);
        rd(CTRL_ADDR, 8'h40);
        wr(CTRL_ADDR, 8'h50);
        far.rx_frame(1'b1, 1'b0, 1'b0);
        rd(CTRL_ADDR, 8'h55);
        // address check in mode 1, then mode 3
        for (m = 0; m < 2; m++) begin
            wr(CTRL_ADDR, (m == 1) ? 8'hF0 : 8'h70);
            far.rx_frame(1'b0, 1'b1, 1'b0);
            far.rx_frame(1'b1, 1'b0, 1'b0);
            rd(CTRL_ADDR, (m == 1) ? 8'hF0 : 8'h70);
            far.rx_frame(1'b1, 1'b1, 1'b0);
            rd(CTRL_ADDR, (m == 1) ? 8'hF5 : 8'h75);
        end
        // mode 0: check bit has no effect, start blocked once done
        wr(CTRL_ADDR, 8'h30);
        far.rx_frame(1'b0, 1'b0, 1'b0);
        rd(CTRL_ADDR, 8'h31);
        check({7'h0, ctrl.rx_start_ok}, 8'h00);
        // interrupt mask, raise and clear
        wr(IRQ_MASK_ADDR, 8'h01);
        rd(IRQ_MASK_ADDR, 8'h01);
        check({7'h0, irq}, 8'h01);
        wr(IRQ_MASK_ADDR, 8'h02);
        check({7'h0, irq}, 8'h00);
        far.tx_frame();
        check({7'h0, irq}, 8'h01);
        repeat (8) @(posedge i_mclk);
        rd(IRQ_STAT_ADDR, 8'h03);
        wr(IRQ_STAT_ADDR, 8'h02);
        check({7'h0, irq}, 8'h00);
        rd(IRQ_STAT_ADDR, 8'h01);
        // error on a frame refused in mode 0 still sets the error flag
        far.rx_frame(1'b0, 1'b0, 1'b1);
        check({7'h0, irq}, 8'h00);
        rd(CTRL_ADDR, 8'h31);
        wr(IRQ_MASK_ADDR, 8'h04);
        check({7'h0, irq}, 8'h01);
        wr(IRQ_STAT_ADDR, 8'h04);
        check({7'h0, irq}, 8'h00);
        rd(IRQ_STAT_ADDR, 8'h01);
        // a write with the clock enable low is lost
        @(posedge i_mclk);
        i_ce <= 1'b0;
        wr(CTRL_ADDR, 8'h00);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        rd(CTRL_ADDR, 8'h31);
        // second reset in mid-run
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(CTRL_ADDR, CTRL_RESET);
        rd(IRQ_MASK_ADDR, 8'h00);
        check({7'h0, irq}, 8'h00);
        results();
    end
endmodule
